// [design/cbhpi_top.sv]
// Card-bus host pin interface: target, parity, request, wake, clock-run
`timescale 1ns/1ps
module cbhpi_top
    import cbhpi_pkg::*;
#(
    parameter int EVENTS = 8,
    parameter int CFG_WORDS = 8,
    parameter int WAKE_CYCLES = WAKE_PULSE_CYCLES,
    parameter logic [31:0] ID_CODE = 32'h1234_5678 // Arbitrary identity value
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Bus inputs
    input wire logic frame_n_i,
    input wire logic irdy_n_i,
    input wire logic idsel_i,
    input wire logic [AD_W-1:0] ad_i,
    input wire logic [CBE_W-1:0] command_byte_enable_lines_i,
    input wire logic par_i,
    input wire logic gnt_n_i,
    input wire logic clkrun_n_i,
    // Bus outputs
    output logic [AD_W-1:0] ad_o,
    output logic ad_oe_o,
    output logic par_o,
    output logic par_oe_o,
    output logic devsel_n_o,
    output logic devsel_oe_o,
    output logic trdy_n_o,
    output logic trdy_oe_o,
    output logic stop_n_o,
    output logic stop_oe_o,
    output logic perr_n_o,
    output logic perr_oe_o,
    output logic req_n_o,
    output logic req_oe_o,
    // Open-drain outputs, pin low while enable is high
    output logic inta_oe_o,
    output logic pme_oe_o,
    output logic clkrun_oe_o,
    // Interrupt events
    input wire logic [EVENTS-1:0] irq_event_i,
    input wire logic [EVENTS-1:0] irq_enable_i,
    input wire logic [EVENTS-1:0] irq_clear_i,
    output logic [EVENTS-1:0] irq_pending_o,
    // Master request
    input wire logic master_req_i,
    output logic master_gnt_o,
    // Wake and clock-run control
    input wire logic wake_on_lan_enable_i,
    input wire logic wake_signal_style_i,
    input wire logic wake_frame_i,
    input wire logic clkrun_enable_i,
    output logic network_wake_indication_o,
    // Boot ROM
    input wire logic [ROM_ADDR_W-1:0] rom_addr_i,
    input wire logic rom_addr_valid_i,
    output logic [ROM_ADDR_W-1:0] boot_rom_address_bus_o,
    output logic boot_rom_address_oe_o
);

    localparam int IDX_W = $clog2(CFG_WORDS);
    localparam int WCNT_W = $clog2(WAKE_CYCLES + 1);

    cbhpi_state_t state_r;
    logic frame_prev_r;
    logic is_write_r;
    logic [IDX_W-1:0] index_r;
    logic [AD_W-1:0] cfg_mem_r [CFG_WORDS];
    logic wr_par_r;
    logic [1:0] perr_step_r;
    logic [1:0] clkrun_cnt_r;
    logic [WCNT_W-1:0] wake_cnt_r;
    logic in_par;
    logic out_par;
    logic addr_hit;
    logic xfer;

    // ==========================================================
    // Parity generators
    cbhpi_parity #(.W(AD_W + CBE_W)) u_in_par (
        .data_i({ad_i, command_byte_enable_lines_i}),
        .par_o(in_par)
    );
    cbhpi_parity #(.W(AD_W + CBE_W)) u_out_par (
        .data_i({ad_o, command_byte_enable_lines_i}),
        .par_o(out_par)
    );

    // ==========================================================
    // Address decode
    // frame start edge
    assign addr_hit = frame_prev_r && !frame_n_i && idsel_i
        && (command_byte_enable_lines_i[3:1] == CMD_CFG_READ[3:1])
        && (ad_i[1:0] == CFG_ADDR_TYPE0);
    assign xfer = (state_r == ST_DATA) && !irdy_n_i;

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
            frame_prev_r <= 1'b1;
        else
            frame_prev_r <= frame_n_i;
    end

    // ==========================================================
    // Target state machine
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_IDLE;
            is_write_r <= 1'b0;
            index_r <= '0;
            wr_par_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (addr_hit)
                    begin
                        state_r <= ST_DATA;
                        is_write_r <= command_byte_enable_lines_i[0];
                        index_r <= ad_i[IDX_W+1:2];
                    end
                ST_DATA:
                    if (xfer)
                    begin
                        state_r <= ST_TURN;
                        wr_par_r <= in_par;
                    end
                ST_TURN:
                    state_r <= ST_FLOAT;
                ST_FLOAT:
                    state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Target pin drive
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            devsel_n_o <= 1'b1;
            devsel_oe_o <= 1'b0;
            trdy_n_o <= 1'b1;
            trdy_oe_o <= 1'b0;
            stop_n_o <= 1'b1;
            stop_oe_o <= 1'b0;
            ad_o <= '0;
            ad_oe_o <= 1'b0;
            par_o <= 1'b0;
            par_oe_o <= 1'b0;
        end
        else
        begin
            par_oe_o <= 1'b0;
            case (state_r)
                ST_IDLE:
                    if (addr_hit)
                    begin
                        devsel_n_o <= 1'b0;
                        devsel_oe_o <= 1'b1;
                        trdy_n_o <= 1'b0;
                        trdy_oe_o <= 1'b1;
                        stop_n_o <= 1'b0;
                        stop_oe_o <= 1'b1;
                        ad_o <= cfg_mem_r[ad_i[IDX_W+1:2]];
                        ad_oe_o <= !command_byte_enable_lines_i[0];
                    end
                ST_DATA:
                    if (xfer)
                    begin
                        devsel_n_o <= 1'b1;
                        trdy_n_o <= 1'b1;
                        stop_n_o <= 1'b1;
                        ad_oe_o <= 1'b0;
                        par_o <= out_par;
                        par_oe_o <= !is_write_r;
                    end
                ST_TURN:
                begin
                    devsel_oe_o <= 1'b0;
                    trdy_oe_o <= 1'b0;
                    stop_oe_o <= 1'b0;
                end
                default:
                    ad_oe_o <= 1'b0;
            endcase
        end
    end

    // ==========================================================
    // Configuration words
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < CFG_WORDS; i++)
                cfg_mem_r[i] <= CFG_RESET_VALUE;
        end
        else
        begin
            cfg_mem_r[CFG_ID_INDEX] <= ID_CODE;
            if (xfer && is_write_r && (index_r != IDX_W'(CFG_ID_INDEX)))
            begin
                for (int b = 0; b < CBE_W; b++)
                    if (!command_byte_enable_lines_i[b])
                        cfg_mem_r[index_r][b*8 +: 8] <= ad_i[b*8 +: 8];
            end
        end
    end

    // ==========================================================
    // Data parity error on writes
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            perr_step_r <= 2'h0;
            perr_n_o <= 1'b1;
            perr_oe_o <= 1'b0;
        end
        else
        begin
            case (perr_step_r)
                2'h0:
                    if (state_r == ST_TURN && is_write_r && par_i != wr_par_r)
                    begin
                        perr_step_r <= 2'h1;
                        perr_n_o <= 1'b0;
                        perr_oe_o <= 1'b1;
                    end
                2'h1:
                begin
                    perr_step_r <= 2'h2;
                    perr_n_o <= 1'b1;
                end
                default:
                begin
                    perr_step_r <= 2'h0;
                    perr_oe_o <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Interrupt
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_pending_o <= '0;
            inta_oe_o <= 1'b0;
        end
        else
        begin
            // Set wins over clear
            irq_pending_o <= (irq_pending_o & ~irq_clear_i) | irq_event_i;
            inta_oe_o <= |(irq_pending_o & irq_enable_i);
        end
    end

    // ==========================================================
    // Bus request
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            req_n_o <= 1'b1;
            req_oe_o <= 1'b0;
            master_gnt_o <= 1'b0;
        end
        else
        begin
            req_n_o <= !master_req_i;
            req_oe_o <= 1'b1;
            master_gnt_o <= master_req_i && !gnt_n_i;
        end
    end

    // ==========================================================
    // Clock-run
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            clkrun_oe_o <= 1'b0;
            clkrun_cnt_r <= 2'h0;
        end
        else if (!clkrun_enable_i)
        begin
            clkrun_oe_o <= 1'b0;
            clkrun_cnt_r <= 2'h0;
        end
        else if (clkrun_oe_o)
        begin
            clkrun_cnt_r <= clkrun_cnt_r + 2'h1;
            if (clkrun_cnt_r == 2'(CLKRUN_HOLD_CYCLES - 1))
                clkrun_oe_o <= 1'b0;
        end
        else if (clkrun_n_i)
        begin
            clkrun_oe_o <= 1'b1;
            clkrun_cnt_r <= 2'h0;
        end
    end

    // ==========================================================
    // Wake
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pme_oe_o <= 1'b0;
            network_wake_indication_o <= 1'b0;
            wake_cnt_r <= '0;
        end
        else if (!wake_on_lan_enable_i)
        begin
            pme_oe_o <= 1'b0;
            wake_cnt_r <= '0;
            network_wake_indication_o <= !wake_signal_style_i;
        end
        else if (wake_cnt_r != '0)
        begin
            wake_cnt_r <= wake_cnt_r - WCNT_W'(1);
            if (wake_cnt_r == WCNT_W'(1))
                network_wake_indication_o <= !wake_signal_style_i;
        end
        else if (wake_frame_i)
        begin
            pme_oe_o <= 1'b1;
            network_wake_indication_o <= wake_signal_style_i;
            wake_cnt_r <= WCNT_W'(WAKE_CYCLES);
        end
        else
            network_wake_indication_o <= !wake_signal_style_i;
    end

    // ==========================================================
    // Boot ROM address
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            boot_rom_address_bus_o <= '0;
            boot_rom_address_oe_o <= 1'b0;
        end
        else
        begin
            boot_rom_address_oe_o <= 1'b1;
            if (rom_addr_valid_i)
                boot_rom_address_bus_o <= rom_addr_i;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence cfg_hit_s;
        (state_r == ST_IDLE) && addr_hit;
    endsequence
    sequence target_claim_s;
        devsel_oe_o && !devsel_n_o && !trdy_n_o;
    endsequence

    irq_drive_a: assert property (
        |(irq_pending_o & irq_enable_i) |=> inta_oe_o) else $error("irq not driven");
    irq_release_a: assert property (
        !(|(irq_pending_o & irq_enable_i)) |=> !inta_oe_o) else $error("irq not released");
    reset_float_a: assert property (@(posedge core_clk_i) disable iff (1'b0)
        rst_i |-> !(ad_oe_o || devsel_oe_o || inta_oe_o || pme_oe_o || req_oe_o || clkrun_oe_o))
        else $error("pin driven in reset");
    grant_pair_a: assert property (
        master_gnt_o |-> !$past(gnt_n_i) && !req_n_o) else $error("grant without request");
    wake_event_a: assert property (
        wake_on_lan_enable_i && wake_frame_i && wake_cnt_r == '0 |=> pme_oe_o)
        else $error("wake event missed");
    wake_style_a: assert property (
        wake_on_lan_enable_i && wake_frame_i && wake_cnt_r == '0 |=>
        network_wake_indication_o == $past(wake_signal_style_i)) else $error("wake style wrong");
    cfg_select_a: assert property (
        state_r == ST_IDLE && !idsel_i |=> !devsel_oe_o) else $error("claim without select");
    read_parity_a: assert property (
        par_oe_o |-> par_o == ^{$past(ad_o), $past(command_byte_enable_lines_i)})
        else $error("read parity wrong");
    perr_flag_a: assert property (
        state_r == ST_TURN && is_write_r && par_i != wr_par_r && perr_step_r == 2'h0
        |=> perr_oe_o && !perr_n_o ##1 perr_n_o) else $error("parity error not flagged");
    clkrun_req_a: assert property (
        clkrun_enable_i && clkrun_n_i && !clkrun_oe_o |=> clkrun_oe_o)
        else $error("clock-run not reasserted");
    clkrun_off_a: assert property (
        !clkrun_enable_i |=> !clkrun_oe_o) else $error("clock-run driven while off");
    stop_claim_a: assert property (
        cfg_hit_s |=> target_claim_s and !stop_n_o) else $error("stop missing");
    devsel_hit_a: assert property (
        cfg_hit_s |=> target_claim_s ##1 devsel_oe_o[*1]) else $error("devsel missing");

endmodule

// [design/cbhpi_pkg.sv]
// Constants and types shared by the card-bus host pin interface
// How it works
// - Interrupt output drives while any enabled pending event exists.
// - During reset every output floats and open-drain pins release.
// - All bus inputs are sampled on the rising clock edge.
// - Device requests the bus; arbiter grant marks the request accepted.
// - Wake enable arms wake mode; wake frame drives power event low.
// - Wake style one gives a high pulse, zero a low pulse.
// - Configuration accesses are answered only with device select asserted.
// - Parity is even across address/data and command/byte enables.
// - The receiver of bad data drives the data parity error signal.
// - Host clock-run deassertion is answered by the device reasserting it.
// - With clock-run disabled the device never drives clock-run.
// - A target ending the transaction asserts stop; the master terminates.
// - As target, device-select is driven once the address decodes as ours.
// - Boot ROM address bus covers 128 kilobytes.
package cbhpi_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int RST_MIN_US = 100;
    localparam int RST_MIN_CYCLES = (RST_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_PULSE_MS = 50;
    localparam int WAKE_PULSE_CYCLES = (WAKE_PULSE_MS * 1000000) / CLK_PERIOD_NS;
    localparam int CLKRUN_HOLD_CYCLES = 2;

    // ==========================================================
    // Bus layout
    localparam int AD_W = 32;
    localparam int CBE_W = 4;
    localparam int ROM_ADDR_W = 17;
    localparam logic [3:0] CMD_CFG_READ = 4'hA;
    localparam logic [3:0] CMD_CFG_WRITE = 4'hB;
    localparam logic [1:0] CFG_ADDR_TYPE0 = 2'h0;
    localparam int CFG_ID_INDEX = 0;
    localparam logic [31:0] CFG_RESET_VALUE = 32'h0000_0000;

    // ==========================================================
    // Target state machine
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DATA,
        ST_TURN,
        ST_FLOAT
    } cbhpi_state_t;

endpackage

// [design/cbhpi_parity.sv]
// Even parity generator over a word
`timescale 1ns/1ps
module cbhpi_parity #(
    parameter int W = 36
) (
    // Word in
    input wire logic [W-1:0] data_i,
    // Parity out
    output logic par_o
);

    // ==========================================================
    // Even parity
    // xor reduction
    assign par_o = ^data_i;

endmodule

// [verification/cbhpi_host.sv]
// Host card-bus controller and arbiter model facing the pin interface
`timescale 1ns/1ps
module cbhpi_host
    import cbhpi_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Device pins as seen on the bus
    input wire logic [AD_W-1:0] dev_ad_i,
    input wire logic dev_par_i,
    input wire logic dev_par_oe_i,
    input wire logic devsel_n_i,
    input wire logic trdy_n_i,
    input wire logic stop_n_i,
    input wire logic perr_n_i,
    input wire logic req_n_i,
    input wire logic clkrun_n_i,
    input wire logic slow_gnt_i,
    // Host drives
    output logic frame_n_o,
    output logic irdy_n_o,
    output logic idsel_o,
    output logic [AD_W-1:0] ad_o,
    output logic [CBE_W-1:0] cbe_o,
    output logic par_o,
    output logic gnt_n_o,
    output logic clkrun_drv_o
);
    logic gnt_q_r;
    logic slow_r;
    logic asked_r;

    initial
    begin
        frame_n_o = 1'b1;
        irdy_n_o = 1'b1;
        idsel_o = 1'b0;
        ad_o = 32'h0000_0000;
        cbe_o = 4'hF;
        par_o = 1'b0;
        slow_r = 1'b0;
    end

    // ==========================================================
    // Arbiter
    // grant follows request, prompt or slow
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            gnt_q_r <= 1'b0;
            gnt_n_o <= 1'b1;
        end
        else
        begin
            gnt_q_r <= !req_n_i;
            gnt_n_o <= !(!req_n_i && (gnt_q_r || !slow_gnt_i));
        end
    end

    // ==========================================================
    // Clock-run, host side
    // host keeps the clock once the device asks
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            asked_r <= 1'b0;
            clkrun_drv_o <= 1'b1;
        end
        else
        begin
            asked_r <= slow_r && (asked_r || (!clkrun_n_i && !clkrun_drv_o));
            clkrun_drv_o <= !slow_r || asked_r;
        end
    end

    task automatic clk_run(input logic slow);
        slow_r = slow;
    endtask

    // ==========================================================
    // Configuration access, one data phase
    task automatic cfg(input logic wr, input logic [2:0] idx, input logic [31:0] wd,
        input logic [3:0] be, input logic sel, input logic bad, output logic [31:0] rd,
        output logic hit, output logic stp, output logic pb, output logic pe);
        int n;
        @(posedge core_clk_i);
        #1;
        frame_n_o = 1'b0;
        idsel_o = sel;
        ad_o = {27'h0, idx, 2'h0};
        cbe_o = wr ? CMD_CFG_WRITE : CMD_CFG_READ;
        @(posedge core_clk_i);
        #1;
        par_o = ^{ad_o, cbe_o};
        frame_n_o = 1'b1;
        irdy_n_o = 1'b0;
        cbe_o = be;
        ad_o = wr ? wd : ~ad_o;
        n = 0;
        do
        begin
            @(posedge core_clk_i);
            n++;
        end while (trdy_n_i !== 1'b0 && n < 6);
        rd = dev_ad_i;
        hit = devsel_n_i === 1'b0;
        stp = stop_n_i === 1'b0;
        #1;
        pb = !(dev_par_oe_i === 1'b1 && dev_par_i === ^{rd, cbe_o});
        irdy_n_o = 1'b1;
        idsel_o = 1'b0;
        par_o = wr ? (^{wd, be} ^ bad) : ~par_o;
        ad_o = ~ad_o;
        @(posedge core_clk_i);
        #1;
        pe = perr_n_i === 1'b0;
        par_o = ~par_o;
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask
endmodule

// [verification/cbhpi_top_test.sv]
// Self-checking bench for the card-bus host pin interface
`timescale 1ns/1ps
module cbhpi_top_test
    import cbhpi_pkg::*;
;
    localparam int WAKE_N = 8;
    localparam logic [31:0] TB_ID = 32'hC0DE_0001; // Arbitrary identity value
    int err_total = 0;
    int samples_checked = 0;
    logic core_clk_i, rst_i, frame_n_i, irdy_n_i, idsel_i, gnt_n_i, host_par, host_cr, slow_gnt;
    logic [AD_W-1:0] host_ad, ad_o;
    logic [CBE_W-1:0] command_byte_enable_lines_i;
    logic ad_oe_o, par_o, par_oe_o, devsel_n_o, devsel_oe_o, trdy_n_o, trdy_oe_o, stop_n_o;
    logic stop_oe_o, perr_n_o, perr_oe_o, req_n_o, req_oe_o, inta_oe_o, pme_oe_o, clkrun_oe_o;
    logic [7:0] irq_event_i, irq_enable_i, irq_clear_i, irq_pending_o;
    logic master_req_i, master_gnt_o, wake_on_lan_enable_i, wake_signal_style_i, wake_frame_i;
    logic clkrun_enable_i, network_wake_indication_o, rom_addr_valid_i, boot_rom_address_oe_o;
    logic [ROM_ADDR_W-1:0] rom_addr_i, boot_rom_address_bus_o;
    wire logic [AD_W-1:0] ad_bus = ad_oe_o ? ad_o : host_ad;
    wire logic par_bus = par_oe_o ? par_o : host_par;
    wire logic clkrun_pin = !(host_cr || clkrun_oe_o);
    wire logic [10:0] all_oe = {ad_oe_o, par_oe_o, devsel_oe_o, trdy_oe_o, stop_oe_o, perr_oe_o,
        req_oe_o, inta_oe_o, pme_oe_o, clkrun_oe_o, boot_rom_address_oe_o};

    cbhpi_top #(.EVENTS(8), .CFG_WORDS(8), .WAKE_CYCLES(WAKE_N), .ID_CODE(TB_ID)) i_dut (
        .core_clk_i, .rst_i, .frame_n_i, .irdy_n_i, .idsel_i, .ad_i(ad_bus),
        .command_byte_enable_lines_i, .par_i(par_bus), .gnt_n_i, .clkrun_n_i(clkrun_pin),
        .ad_o, .ad_oe_o, .par_o, .par_oe_o, .devsel_n_o, .devsel_oe_o, .trdy_n_o, .trdy_oe_o,
        .stop_n_o, .stop_oe_o, .perr_n_o, .perr_oe_o, .req_n_o, .req_oe_o, .inta_oe_o,
        .pme_oe_o, .clkrun_oe_o, .irq_event_i, .irq_enable_i, .irq_clear_i, .irq_pending_o,
        .master_req_i, .master_gnt_o, .wake_on_lan_enable_i, .wake_signal_style_i,
        .wake_frame_i, .clkrun_enable_i, .network_wake_indication_o, .rom_addr_i,
        .rom_addr_valid_i, .boot_rom_address_bus_o, .boot_rom_address_oe_o);

    cbhpi_host i_host (
        .core_clk_i, .rst_i, .dev_ad_i(ad_bus), .dev_par_i(par_bus), .dev_par_oe_i(par_oe_o),
        .devsel_n_i(devsel_oe_o ? devsel_n_o : 1'b1), .trdy_n_i(trdy_oe_o ? trdy_n_o : 1'b1),
        .stop_n_i(stop_oe_o ? stop_n_o : 1'b1), .perr_n_i(perr_oe_o ? perr_n_o : 1'b1),
        .req_n_i(req_oe_o ? req_n_o : 1'b1), .clkrun_n_i(clkrun_pin), .slow_gnt_i(slow_gnt),
        .frame_n_o(frame_n_i), .irdy_n_o(irdy_n_i), .idsel_o(idsel_i), .ad_o(host_ad),
        .cbe_o(command_byte_enable_lines_i), .par_o(host_par), .gnt_n_o(gnt_n_i),
        .clkrun_drv_o(host_cr));

    // ==========================================================
    // Clock, checks and closing
    // bus clock at 20 MHz
    initial
    begin
        core_clk_i = 1'b0;
        forever #(CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic got, input logic exp);
        chk_w({31'h0, got}, {31'h0, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rst_i = 1'b1;
        tick(10);
        chk_w({21'h0, all_oe}, 32'h0);
        rst_i = 1'b0;
        tick(2);
    endtask

    task automatic cfg_rd(input logic [2:0] idx, input logic sel, input logic [31:0] exp);
        logic [31:0] rd;
        logic hit, stp, pb, pe;
        i_host.cfg(1'b0, idx, 32'h0, 4'h0, sel, 1'b0, rd, hit, stp, pb, pe);
        chk_b(hit, sel);
        if (sel)
        begin
            chk_w(rd, exp);
            chk_b(stp, 1'b1);
            chk_b(pb, 1'b0);
        end
    endtask

    task automatic cfg_wr(input logic [2:0] idx, input logic [31:0] wd, input logic [3:0] be,
        input logic bad);
        logic [31:0] rd;
        logic hit, stp, pb, pe;
        i_host.cfg(1'b1, idx, wd, be, 1'b1, bad, rd, hit, stp, pb, pe);
        chk_b(hit, 1'b1);
        chk_b(stp, 1'b1);
        chk_b(pe, bad);
    endtask

    task automatic t_cfg();
        cfg_rd(3'h0, 1'b1, TB_ID);
        cfg_rd(3'h3, 1'b1, CFG_RESET_VALUE);
        cfg_wr(3'h1, 32'hA5A5_5A5A, 4'h0, 1'b0);
        cfg_rd(3'h1, 1'b1, 32'hA5A5_5A5A);
        cfg_wr(3'h1, 32'hFFFF_FFFF, 4'hE, 1'b0);
        cfg_rd(3'h1, 1'b1, 32'hA5A5_5AFF);
        cfg_wr(3'h0, 32'h0000_0000, 4'h0, 1'b0);
        cfg_rd(3'h0, 1'b1, TB_ID);
        cfg_rd(3'h1, 1'b0, 32'h0);
        cfg_wr(3'h2, 32'h1357_9BDF, 4'h0, 1'b1);
    endtask

    task automatic t_irq();
        irq_enable_i = 8'h05;
        irq_event_i = 8'h02;
        tick(1);
        irq_event_i = 8'h00;
        tick(3);
        chk_b(inta_oe_o, 1'b0);
        irq_event_i = 8'h05;
        tick(1);
        irq_event_i = 8'h00;
        tick(1);
        chk_b(inta_oe_o, 1'b1);
        chk_w({24'h0, irq_pending_o}, 32'h07);
        irq_clear_i = 8'h01;
        tick(1);
        irq_clear_i = 8'h04;
        tick(1);
        chk_b(inta_oe_o, 1'b1);
        irq_clear_i = 8'h00;
        tick(2);
        chk_b(inta_oe_o, 1'b0);
        irq_enable_i = 8'h02;
        tick(2);
        chk_b(inta_oe_o, 1'b1);
        irq_clear_i = 8'h02;
        tick(1);
        irq_clear_i = 8'h00;
        tick(2);
        chk_b(inta_oe_o, 1'b0);
        irq_event_i = 8'h08;
        irq_clear_i = 8'h08;
        tick(1);
        {irq_event_i, irq_clear_i} = 16'h0;
        chk_w({24'h0, irq_pending_o}, 32'h08);
    endtask

    task automatic t_req(input logic slow);
        int n;
        slow_gnt = slow;
        master_req_i = 1'b1;
        tick(1);
        chk_b(req_n_o, 1'b0);
        chk_b(req_oe_o, 1'b1);
        n = 0;
        while (master_gnt_o !== 1'b1 && n < 8)
        begin
            tick(1);
            n++;
        end
        chk_w(n, slow ? 32'h3 : 32'h2);
        master_req_i = 1'b0;
        tick(2);
        chk_b(req_n_o, 1'b1);
        chk_b(master_gnt_o, 1'b0);
    endtask

    task automatic t_wake(input logic s);
        int n;
        wake_signal_style_i = s;
        wake_frame_i = 1'b1;
        tick(1);
        wake_frame_i = 1'b0;
        tick(2);
        chk_b(pme_oe_o, 1'b0);
        chk_b(network_wake_indication_o, !s);
        wake_on_lan_enable_i = 1'b1;
        tick(1);
        wake_frame_i = 1'b1;
        tick(1);
        n = 0;
        for (int i = 0; i < 14; i++)
        begin
            wake_frame_i = (i == 3);
            if (i == 0)
                chk_b(pme_oe_o, 1'b1);
            if (network_wake_indication_o === s)
                n++;
            tick(1);
        end
        chk_w(n, WAKE_N);
        chk_b(pme_oe_o, 1'b1);
        wake_on_lan_enable_i = 1'b0;
        tick(2);
        chk_b(pme_oe_o, 1'b0);
    endtask

    task automatic t_clkrun(input logic en);
        int n;
        clkrun_enable_i = en;
        tick(2);
        i_host.clk_run(1'b1);
        n = 0;
        repeat (10)
        begin
            tick(1);
            n += (clkrun_oe_o === 1'b1);
        end
        chk_w(n, en ? CLKRUN_HOLD_CYCLES : 0);
        i_host.clk_run(1'b0);
        tick(2);
    endtask

    task automatic t_rom(input logic [ROM_ADDR_W-1:0] a);
        rom_addr_i = a;
        rom_addr_valid_i = 1'b1;
        tick(1);
        rom_addr_valid_i = 1'b0;
        rom_addr_i = ~a;
        tick(1);
        chk_w({15'h0, boot_rom_address_bus_o}, {15'h0, a});
        chk_b(boot_rom_address_oe_o, 1'b1);
    endtask

    initial
    begin
        #(CLK_PERIOD_NS * 4000);
        err_total++;
        end_sim();
    end

    initial
    begin
        {irq_event_i, irq_enable_i, irq_clear_i} = 24'h0;
        {master_req_i, wake_on_lan_enable_i, wake_signal_style_i, wake_frame_i} = 4'h0;
        {clkrun_enable_i, rom_addr_valid_i, slow_gnt} = 3'h0;
        rom_addr_i = 17'h0_0000;
        rst_i = 1'b1;
        t_reset();
        t_cfg();
        t_irq();
        t_req(1'b0);
        t_req(1'b1);
        t_wake(1'b1);
        t_wake(1'b0);
        t_clkrun(1'b0);
        t_clkrun(1'b1);
        t_rom(17'h1FFFF);
        t_rom(17'h02A5C);
        irq_enable_i = 8'h01;
        irq_event_i = 8'h01;
        master_req_i = 1'b1;
        tick(1);
        irq_event_i = 8'h00;
        tick(2);
        t_reset();
        chk_w({24'h0, irq_pending_o}, 32'h0);
        chk_b(inta_oe_o, 1'b0);
        chk_b(req_n_o, 1'b0);
        end_sim();
    end
endmodule
